// *** hdl/tsr_conv_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsr_conv_seq #(
  parameter int unsigned POWERUP_CYC    = 300_000,
  parameter int unsigned CONV_FAULT_CYC = 330_000,
  parameter int unsigned CONV_DIODE_CYC = 630_000,
  parameter int unsigned RATE1_CYC      = 3_640_000,
  parameter int unsigned RATE2_CYC      = 10_000_000,
  parameter int unsigned RATE3_CYC      = 25_000_000,
  parameter int          CNT_W          = 25
) (
  input  wire logic       clock_in,       // System clock
  input  wire logic       sys_rst_in,     // Synchronous reset, active high
  input  wire logic       standby_in,     // Standby selected
  input  wire logic [1:0] rate_in,        // Conversion rate code
  input  wire logic       one_shot_in,    // One-shot write strobe
  input  wire logic       diode_fault_in, // Remote diode missing
  output logic            start_out,      // Conversion start pulse
  output logic            done_out,       // Conversion done pulse
  output logic            busy_out,       // Conversion in progress
  output logic            not_ready_out   // Start-up still running
);
  import tsr_pkg::*;

  typedef struct packed {
    tsr_seq_state_t   state;
    logic [CNT_W-1:0] elapsed;
    logic             short_conv;
    logic             start;
    logic             done;
    logic             busy;
    logic             not_ready;
  } tsr_seq_reg_t;

  tsr_seq_reg_t st_ff;
  tsr_seq_reg_t nxt_st;
  logic [CNT_W-1:0] period_end;
  logic [CNT_W-1:0] conv_end;

  always_comb begin
    unique case (rate_in)
      2'b00: period_end = '0;
      2'b01: period_end = CNT_W'(RATE1_CYC - 1);
      2'b10: period_end = CNT_W'(RATE2_CYC - 1);
      2'b11: period_end = CNT_W'(RATE3_CYC - 1);
    endcase
    conv_end = st_ff.short_conv ? CNT_W'(CONV_FAULT_CYC - 1)
                                : CNT_W'(CONV_DIODE_CYC - 1);
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.start   = 1'b0;
    nxt_st.done    = 1'b0;
    nxt_st.elapsed = st_ff.elapsed + CNT_W'(1);
    unique case (st_ff.state)
      SEQ_POWERUP: begin
        if (st_ff.elapsed >= CNT_W'(POWERUP_CYC - 1)) begin
          nxt_st.state     = SEQ_IDLE;
          nxt_st.not_ready = 1'b0;
        end
      end
      SEQ_IDLE: begin
        // A one-shot in run mode is dropped; run mode converts anyway
        if (!standby_in || one_shot_in) begin
          nxt_st.state      = SEQ_CONVERT;
          nxt_st.start      = 1'b1;
          nxt_st.busy       = 1'b1;
          nxt_st.elapsed    = '0;
          nxt_st.short_conv = diode_fault_in;
        end
      end
      SEQ_CONVERT: begin
        if (st_ff.elapsed >= conv_end) begin
          nxt_st.done  = 1'b1;
          nxt_st.busy  = 1'b0;
          nxt_st.state = standby_in ? SEQ_IDLE : SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        // Period counts from conversion start, so a short period runs back to back
        if (standby_in || st_ff.elapsed >= period_end) begin
          nxt_st.state = SEQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_ff.state      <= SEQ_POWERUP;
      st_ff.elapsed    <= '0;
      st_ff.short_conv <= 1'b0;
      st_ff.start      <= 1'b0;
      st_ff.done       <= 1'b0;
      st_ff.busy       <= 1'b0;
      st_ff.not_ready  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign start_out     = st_ff.start;
  assign done_out      = st_ff.done;
  assign busy_out      = st_ff.busy;
  assign not_ready_out = st_ff.not_ready;
endmodule
`default_nettype wire

// *** hdl/tsr_low_lock.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsr_low_lock (
  input  wire logic       clock_in,     // System clock
  input  wire logic       sys_rst_in,   // Synchronous reset, active high
  input  wire logic       hi_read_in,   // High byte read strobe
  input  wire logic       lo_read_in,   // Low byte read strobe
  input  wire logic [7:0] live_low_in,  // Current low byte
  output logic      [7:0] low_view_out  // Low byte as the host sees it
);
  import tsr_pkg::*;

  typedef struct packed {
    logic       locked;
    logic [7:0] held;
  } tsr_lock_reg_t;

  tsr_lock_reg_t st_ff;
  tsr_lock_reg_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (hi_read_in) begin
      nxt_st.locked = 1'b1;
      nxt_st.held   = live_low_in;
    end else if (lo_read_in) begin
      nxt_st.locked = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Combinational so a low read right after the high read sees the frozen byte
  assign low_view_out = st_ff.locked ? st_ff.held : live_low_in;
endmodule
`default_nettype wire

// *** hdl/tsr_pkg.sv ***
package tsr_pkg;

  localparam logic [7:0] ADDR_STATUS1      = 8'h02;
  localparam logic [7:0] ADDR_GEN_CFG      = 8'h03;
  localparam logic [7:0] ADDR_GEN_CFG_ALT  = 8'h09;
  localparam logic [7:0] ADDR_RATE         = 8'h04;
  localparam logic [7:0] ADDR_RATE_ALT     = 8'h0a;
  localparam logic [7:0] ADDR_ONE_SHOT     = 8'h0f;
  localparam logic [7:0] ADDR_S_HI         = 8'h01;
  localparam logic [7:0] ADDR_S_LO         = 8'h10;
  localparam logic [7:0] ADDR_OFF_HI       = 8'h11;
  localparam logic [7:0] ADDR_OFF_LO       = 8'h12;
  localparam logic [7:0] ADDR_U_HI         = 8'h31;
  localparam logic [7:0] ADDR_U_LO         = 8'h32;
  localparam logic [7:0] ADDR_STATUS2      = 8'h33;
  localparam logic [7:0] ADDR_DIODE_CFG    = 8'hbf;

  localparam logic [7:0] GEN_CFG_RST       = 8'h00;
  localparam logic [7:0] GEN_CFG_MASK      = 8'h5e;
  localparam logic [7:0] RATE_RST          = 8'h02;
  localparam logic [7:0] RATE_MASK         = 8'h03;
  localparam logic [7:0] DIODE_CFG_RST     = 8'h1f;
  localparam logic [7:0] DIODE_CFG_MASK    = 8'h7e;
  localparam logic [7:0] DIODE_CFG_ONES    = 8'h01;
  localparam logic [7:0] OFF_HI_RST        = 8'h00;
  localparam logic [7:0] OFF_LO_RST        = 8'h00;
  localparam logic [7:0] OFF_LO_MASK       = 8'he0;
  localparam logic [7:0] LO_MASK_FILT_OFF  = 8'he0;
  localparam logic [7:0] LO_MASK_FILT_ON   = 8'hf8;
  localparam logic [7:0] FAULT_S_HI        = 8'h80;
  localparam logic [7:0] FAULT_LO          = 8'h00;
  localparam logic [7:0] FAULT_U_HI        = 8'h00;

  localparam int GEN_STANDBY_BIT   = 6;
  localparam int GEN_RCRIT_MASK    = 4;
  localparam int GEN_ROS_MASK      = 3;
  localparam int GEN_LCRIT_MASK    = 2;
  localparam int GEN_LOS_MASK      = 1;
  localparam int DC_PIN_FUNC_BIT   = 6;
  localparam int DC_FAULT_OS_BIT   = 5;
  localparam int DC_FAULT_CRIT_BIT = 4;
  localparam int DC_MODEL_BIT      = 3;
  localparam int DC_FILT_HI_BIT    = 2;
  localparam int DC_FILT_LO_BIT    = 1;

  localparam int CLK_FREQ_HZ       = 10_000_000;
  localparam int CYC_PER_US        = CLK_FREQ_HZ / 1_000_000;
  localparam int T_POWERUP_US      = 30_000;
  localparam int T_CONV_FAULT_US   = 33_000;
  localparam int T_CONV_DIODE_US   = 63_000;
  localparam int T_RATE1_US        = 364_000;
  localparam int T_RATE2_US        = 1_000_000;
  localparam int T_RATE3_US        = 2_500_000;
  localparam int POWERUP_CYC       = T_POWERUP_US * CYC_PER_US;
  localparam int CONV_FAULT_CYC    = T_CONV_FAULT_US * CYC_PER_US;
  localparam int CONV_DIODE_CYC    = T_CONV_DIODE_US * CYC_PER_US;
  localparam int RATE1_CYC         = T_RATE1_US * CYC_PER_US;
  localparam int RATE2_CYC         = T_RATE2_US * CYC_PER_US;
  localparam int RATE3_CYC         = T_RATE3_US * CYC_PER_US;
  localparam int CNT_W             = 25;

  typedef enum logic [1:0] {SEQ_POWERUP, SEQ_IDLE, SEQ_CONVERT, SEQ_WAIT} tsr_seq_state_t;

  typedef struct packed {
    logic [7:0] s_hi;
    logic [7:0] s_lo;
    logic [7:0] u_hi;
    logic [7:0] u_lo;
  } tsr_result_t;

  typedef struct packed {
    logic remote_overtemp_flag;
    logic remote_critical_flag;
    logic local_limit_flag;
    logic diode_fault;
    logic discrete_transistor_detect;
  } tsr_sense_t;

  typedef struct packed {
    logic       transistor_model_select;
    logic       remote_filter_sel_hi;
    logic       remote_filter_sel_lo;
    logic [7:0] offset_high;
    logic [7:0] offset_low;
  } tsr_front_cfg_t;

endpackage

// *** hdl/tsr_reg_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsr_reg_bank #(
  parameter int unsigned POWERUP_CYC    = tsr_pkg::POWERUP_CYC,
  parameter int unsigned CONV_FAULT_CYC = tsr_pkg::CONV_FAULT_CYC,
  parameter int unsigned CONV_DIODE_CYC = tsr_pkg::CONV_DIODE_CYC,
  parameter int unsigned RATE1_CYC      = tsr_pkg::RATE1_CYC,
  parameter int unsigned RATE2_CYC      = tsr_pkg::RATE2_CYC,
  parameter int unsigned RATE3_CYC      = tsr_pkg::RATE3_CYC
) (
  input  wire logic                   clock_in,            // System clock
  input  wire logic                   sys_rst_in,          // Synchronous reset
  input  wire logic [7:0]             reg_addr_in,         // Register address
  input  wire logic                   reg_wr_in,           // Write strobe
  input  wire logic [7:0]             reg_wdata_in,        // Write data
  input  wire logic                   reg_rd_in,           // Read strobe
  output logic      [7:0]             reg_rdata_out,       // Read data
  input  wire logic signed [13:0]     remote_temp_in,      // Remote temp, 1/32 degree
  input  wire tsr_pkg::tsr_sense_t    sense_in,            // Limit and diode flags
  output tsr_pkg::tsr_front_cfg_t     front_cfg_out,       // Front end settings
  output logic                        conv_start_out,      // Conversion start pulse
  output logic                        overtemp_alert_out,  // Over-temp alert
  output logic                        critical_alert_out,  // Critical alert
  output logic                        alert_pin_mode_out   // Shared pin is alert
);
  import tsr_pkg::*;

  typedef struct packed {
    logic [7:0]  gen_cfg;
    logic [7:0]  rate;
    logic [7:0]  diode_cfg;
    logic [7:0]  off_hi;
    logic [7:0]  off_lo;
    tsr_result_t res;
    logic        fault;
    logic [7:0]  rdata;
    logic        os_alert;
    logic        crit_alert;
  } tsr_bank_reg_t;

  tsr_bank_reg_t st_ff;
  tsr_bank_reg_t nxt_st;

  logic        seq_start;
  logic        seq_done;
  logic        seq_busy;
  logic        seq_not_ready;
  logic        rd_s_hi;
  logic        rd_s_lo;
  logic        rd_u_hi;
  logic        rd_u_lo;
  logic [7:0]  s_lo_view;
  logic [7:0]  u_lo_view;
  logic        filter_on;
  logic        one_shot;
  tsr_result_t fresh;
  logic [7:0]  status1;
  logic [7:0]  status2;

  function automatic logic is_gen_cfg(input logic [7:0] a);
    return (a == ADDR_GEN_CFG) || (a == ADDR_GEN_CFG_ALT);
  endfunction

  function automatic logic is_rate(input logic [7:0] a);
    return (a == ADDR_RATE) || (a == ADDR_RATE_ALT);
  endfunction

  // Builds all four result bytes from one conversion
  function automatic tsr_result_t format_result(input logic signed [13:0] t,
                                                input logic               filt,
                                                input logic               fault);
    logic signed [13:0] c;
    logic [7:0]         lo_mask;
    tsr_result_t        r;
    c       = t;
    lo_mask = filt ? LO_MASK_FILT_ON : LO_MASK_FILT_OFF;
    if (t > 14'sd4095) begin
      c = 14'sd4095;
    end else if (t < -14'sd4096) begin
      c = -14'sd4096;
    end
    r.s_hi = c[12:5];
    r.s_lo = {c[4:0], 3'b000} & lo_mask;
    if (t < 14'sd0) begin
      r.u_hi = 8'h00;
      r.u_lo = 8'h00;
    end else begin
      r.u_hi = t[12:5];
      r.u_lo = {t[4:0], 3'b000} & lo_mask;
    end
    if (fault) begin
      r.s_hi = FAULT_S_HI;
      r.s_lo = FAULT_LO;
      r.u_hi = FAULT_U_HI;
      r.u_lo = FAULT_LO;
    end
    return r;
  endfunction

  assign filter_on = st_ff.diode_cfg[DC_FILT_HI_BIT] & st_ff.diode_cfg[DC_FILT_LO_BIT];
  assign rd_s_hi   = reg_rd_in && (reg_addr_in == ADDR_S_HI);
  assign rd_s_lo   = reg_rd_in && (reg_addr_in == ADDR_S_LO);
  assign rd_u_hi   = reg_rd_in && (reg_addr_in == ADDR_U_HI);
  assign rd_u_lo   = reg_rd_in && (reg_addr_in == ADDR_U_LO);
  assign one_shot  = reg_wr_in && (reg_addr_in == ADDR_ONE_SHOT)
                     && st_ff.gen_cfg[GEN_STANDBY_BIT];

  tsr_conv_seq #(
    .POWERUP_CYC    (POWERUP_CYC),
    .CONV_FAULT_CYC (CONV_FAULT_CYC),
    .CONV_DIODE_CYC (CONV_DIODE_CYC),
    .RATE1_CYC      (RATE1_CYC),
    .RATE2_CYC      (RATE2_CYC),
    .RATE3_CYC      (RATE3_CYC),
    .CNT_W          (CNT_W)
  ) u_seq (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .standby_in     (st_ff.gen_cfg[GEN_STANDBY_BIT]),
    .rate_in        (st_ff.rate[1:0]),
    .one_shot_in    (one_shot),
    .diode_fault_in (sense_in.diode_fault),
    .start_out      (seq_start),
    .done_out       (seq_done),
    .busy_out       (seq_busy),
    .not_ready_out  (seq_not_ready)
  );

  tsr_low_lock u_lock_signed (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .hi_read_in   (rd_s_hi),
    .lo_read_in   (rd_s_lo),
    .live_low_in  (st_ff.res.s_lo),
    .low_view_out (s_lo_view)
  );

  tsr_low_lock u_lock_unsigned (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .hi_read_in   (rd_u_hi),
    .lo_read_in   (rd_u_lo),
    .live_low_in  (st_ff.res.u_lo),
    .low_view_out (u_lo_view)
  );

  always_comb begin
    fresh   = format_result(remote_temp_in, filter_on, sense_in.diode_fault);
    status1 = {seq_busy, 2'b00, sense_in.remote_overtemp_flag, 1'b0,
               st_ff.fault, sense_in.remote_critical_flag,
               sense_in.local_limit_flag};
    status2 = {seq_not_ready,
               sense_in.discrete_transistor_detect & st_ff.diode_cfg[DC_MODEL_BIT],
               6'b000000};
  end

  always_comb begin
    nxt_st = st_ff;
    if (seq_done) begin
      nxt_st.res   = fresh;
      nxt_st.fault = sense_in.diode_fault;
    end
    // Writes to addresses outside the writable set fall through untouched
    if (reg_wr_in) begin
      if (is_gen_cfg(reg_addr_in)) begin
        nxt_st.gen_cfg = reg_wdata_in & GEN_CFG_MASK;
      end else if (is_rate(reg_addr_in)) begin
        nxt_st.rate = reg_wdata_in & RATE_MASK;
      end else if (reg_addr_in == ADDR_DIODE_CFG) begin
        nxt_st.diode_cfg = (reg_wdata_in & DIODE_CFG_MASK) | DIODE_CFG_ONES;
      end else if (reg_addr_in == ADDR_OFF_HI) begin
        nxt_st.off_hi = reg_wdata_in;
      end else if (reg_addr_in == ADDR_OFF_LO) begin
        nxt_st.off_lo = reg_wdata_in & OFF_LO_MASK;
      end
    end
    if (reg_rd_in) begin
      if (is_gen_cfg(reg_addr_in)) begin
        nxt_st.rdata = st_ff.gen_cfg;
      end else if (is_rate(reg_addr_in)) begin
        nxt_st.rdata = st_ff.rate;
      end else begin
        unique case (reg_addr_in)
          ADDR_STATUS1:   nxt_st.rdata = status1;
          ADDR_STATUS2:   nxt_st.rdata = status2;
          ADDR_S_HI:      nxt_st.rdata = st_ff.res.s_hi;
          ADDR_S_LO:      nxt_st.rdata = s_lo_view;
          ADDR_U_HI:      nxt_st.rdata = st_ff.res.u_hi;
          ADDR_U_LO:      nxt_st.rdata = u_lo_view;
          ADDR_OFF_HI:    nxt_st.rdata = st_ff.off_hi;
          ADDR_OFF_LO:    nxt_st.rdata = st_ff.off_lo;
          ADDR_DIODE_CFG: nxt_st.rdata = st_ff.diode_cfg;
          default:        nxt_st.rdata = 8'h00;
        endcase
      end
    end
    // A missing diode drives the alerts only where its mask is clear
    // Gate on the incoming pin mode so the over-temp alert never outlives a switch to address input
    nxt_st.os_alert   = nxt_st.diode_cfg[DC_PIN_FUNC_BIT] & (
                          (sense_in.remote_overtemp_flag & ~st_ff.gen_cfg[GEN_ROS_MASK])
                        | (sense_in.local_limit_flag & ~st_ff.gen_cfg[GEN_LOS_MASK])
                        | (sense_in.diode_fault & ~st_ff.diode_cfg[DC_FAULT_OS_BIT]));
    nxt_st.crit_alert = (sense_in.remote_critical_flag & ~st_ff.gen_cfg[GEN_RCRIT_MASK])
                      | (sense_in.local_limit_flag & ~st_ff.gen_cfg[GEN_LCRIT_MASK])
                      | (sense_in.diode_fault & ~st_ff.diode_cfg[DC_FAULT_CRIT_BIT]);
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_ff.gen_cfg    <= GEN_CFG_RST;
      st_ff.rate       <= RATE_RST;
      st_ff.diode_cfg  <= DIODE_CFG_RST;
      st_ff.off_hi     <= OFF_HI_RST;
      st_ff.off_lo     <= OFF_LO_RST;
      st_ff.res        <= '0;
      st_ff.fault      <= 1'b0;
      st_ff.rdata      <= 8'h00;
      st_ff.os_alert   <= 1'b0;
      st_ff.crit_alert <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out                         = st_ff.rdata;
  assign conv_start_out                        = seq_start;
  assign overtemp_alert_out                    = st_ff.os_alert;
  assign critical_alert_out                    = st_ff.crit_alert;
  assign alert_pin_mode_out                    = st_ff.diode_cfg[DC_PIN_FUNC_BIT];
  assign front_cfg_out.transistor_model_select = st_ff.diode_cfg[DC_MODEL_BIT];
  assign front_cfg_out.remote_filter_sel_hi    = st_ff.diode_cfg[DC_FILT_HI_BIT];
  assign front_cfg_out.remote_filter_sel_lo    = st_ff.diode_cfg[DC_FILT_LO_BIT];
  assign front_cfg_out.offset_high             = st_ff.off_hi;
  assign front_cfg_out.offset_low              = st_ff.off_lo;
endmodule
`default_nettype wire

// *** testbench/tsr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
  input  wire logic       clock_in,      // System clock
  output logic      [7:0] reg_addr_out,  // Register address
  output logic            reg_wr_out,    // Write strobe
  output logic      [7:0] reg_wdata_out, // Write data
  output logic            reg_rd_out,    // Read strobe
  input  wire logic [7:0] reg_rdata_in   // Read data
);
  initial begin
    reg_addr_out  = 8'h00;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out    = 1'b0;
  end
  // Released lines show the inverse, so late sampling in the design reads junk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge clock_in);
    reg_wr_out    <= 1'b0;
    reg_addr_out  <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge clock_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~a;
    #1;
    d = reg_rdata_in;
  endtask
endmodule
`default_nettype wire

// *** testbench/tsr_reg_bank_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsr_reg_bank_monitor
  import tsr_pkg::*;
(
  input wire logic                    clock_in,           // System clock
  input wire logic                    sys_rst_in,         // Synchronous reset
  input wire logic [7:0]              reg_addr_in,        // Register address
  input wire logic                    reg_wr_in,          // Write strobe
  input wire logic [7:0]              reg_wdata_in,       // Write data
  input wire logic                    reg_rd_in,          // Read strobe
  input wire logic [7:0]              reg_rdata_out,      // Read data
  input wire tsr_pkg::tsr_front_cfg_t front_cfg_out,      // Front end settings
  input wire logic                    conv_start_out,     // Conversion start
  input wire logic                    overtemp_alert_out, // Over-temp alert
  input wire logic                    alert_pin_mode_out  // Shared pin mode
);
  logic [7:0] ra_ff, wa_ff, wd_ff, sb_ff;
  logic [3:0] os_ff;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ra_ff <= 8'h00;
      wa_ff <= 8'h00;
      sb_ff <= 8'h00;
      os_ff <= 4'hf;
    end else begin
      ra_ff <= reg_rd_in ? reg_addr_in : 8'h00;
      wa_ff <= reg_wr_in ? reg_addr_in : 8'h00;
      os_ff <= (reg_wr_in && reg_addr_in == ADDR_ONE_SHOT) ? 4'h0 : os_ff + {3'h0, os_ff != 4'hf};
      // Standby counts only once settled, so a start already in flight is not blamed
      if (reg_wr_in && (reg_addr_in == ADDR_GEN_CFG || reg_addr_in == ADDR_GEN_CFG_ALT))
        sb_ff <= {7'h00, reg_wdata_in[GEN_STANDBY_BIT]};
      else
        sb_ff <= sb_ff + {7'h00, sb_ff != 8'h00 && sb_ff != 8'hff};
    end
    wd_ff <= reg_wdata_in;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  pin_gate_a: assert property (!alert_pin_mode_out |-> !overtemp_alert_out)
    else $error("alert driven while pin is address input");
  pin_follow_a: assert property (wa_ff == ADDR_DIODE_CFG |-> alert_pin_mode_out == wd_ff[6])
    else $error("pin mode does not follow written bit");
  diode_fields_a: assert property (wa_ff == ADDR_DIODE_CFG |->
    {front_cfg_out.transistor_model_select, front_cfg_out.remote_filter_sel_hi,
     front_cfg_out.remote_filter_sel_lo} == wd_ff[3:1])
    else $error("model or filter select does not follow write");
  offset_hi_a: assert property (wa_ff == ADDR_OFF_HI |-> front_cfg_out.offset_high == wd_ff)
    else $error("offset high not taken");
  diode_rsv_a: assert property (ra_ff == ADDR_DIODE_CFG |-> !reg_rdata_out[7] && reg_rdata_out[0])
    else $error("diode config reserved bits wrong");
  gen_rsv_a: assert property (ra_ff == ADDR_GEN_CFG |-> (reg_rdata_out & 8'ha1) == 8'h00)
    else $error("general config reserved bits set");
  status_rsv_a: assert property (ra_ff == ADDR_STATUS1 |-> (reg_rdata_out & 8'h68) == 8'h00)
    else $error("status reserved bits set");
  standby_hold_a: assert property (conv_start_out && sb_ff > 8'h08 |-> os_ff < 4'h6)
    else $error("conversion started in standby without trigger");
  start_pulse_a: assert property ($rose(conv_start_out) |=> $fell(conv_start_out))
    else $error("start pulse longer than one cycle");
  one_shot_c: cover property (conv_start_out && sb_ff > 8'h08);
  pair_c: cover property (ra_ff == ADDR_U_HI ##2 ra_ff == ADDR_U_LO);
  pin_c: cover property (wa_ff == ADDR_DIODE_CFG && alert_pin_mode_out);
endmodule
bind tsr_reg_bank tsr_reg_bank_monitor mon (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .front_cfg_out(front_cfg_out),
  .conv_start_out(conv_start_out), .overtemp_alert_out(overtemp_alert_out),
  .alert_pin_mode_out(alert_pin_mode_out));
`default_nettype wire

// *** testbench/tsr_reg_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsr_reg_bank_tb;
  import tsr_pkg::*;
  localparam int CD = 50;
  logic               clock_in, sys_rst_in, wr, rd, start, pin, crit;
  logic [7:0]         addr, wd, rdata;
  logic signed [13:0] temp;
  tsr_sense_t         sense;
  tsr_front_cfg_t     fcfg;
  tsr_result_t        e;
  int                 error_cnt, comparisons, seed, t, n, starts;
  logic [7:0] wa [5] = '{8'h03, 8'h04, 8'hbf, 8'h11, 8'h12};
  logic [7:0] rv [5] = '{8'h00, 8'h02, 8'h1f, 8'h00, 8'h00};
  logic [7:0] we [5] = '{8'h5e, 8'h03, 8'h7f, 8'hff, 8'he0};
  tsr_reg_bank #(.POWERUP_CYC(50), .CONV_FAULT_CYC(30), .CONV_DIODE_CYC(CD),
    .RATE1_CYC(100), .RATE2_CYC(200), .RATE3_CYC(300)) dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wd), .reg_rd_in(rd), .reg_rdata_out(rdata), .remote_temp_in(temp),
    .sense_in(sense), .front_cfg_out(fcfg), .conv_start_out(start),
    .overtemp_alert_out(), .critical_alert_out(crit), .alert_pin_mode_out(pin));
  tsr_host_model host (.clock_in(clock_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wd), .reg_rd_out(rd), .reg_rdata_in(rdata));
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) if (start === 1'b1) starts++;
  task automatic cmp(input string nm, input logic [7:0] ex, input logic [7:0] got);
    comparisons++;
    if (got !== ex) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk(input logic [7:0] ra, input logic [7:0] ex, input logic [7:0] m = 8'hff);
    logic [7:0] v;
    host.rd(ra, v);
    cmp($sformatf("reg %h", ra), ex & m, v & m);
  endtask
  function automatic tsr_result_t model(input int tv, input bit f, input bit flt);
    int         ts;
    logic [7:0] m;
    ts = (tv > 4095) ? 4095 : tv;
    m = f ? LO_MASK_FILT_ON : LO_MASK_FILT_OFF;
    if (flt) return '{8'h80, 8'h00, 8'h00, 8'h00};
    return '{8'(ts >> 5), 8'(ts << 3) & m, 8'(tv >> 5), 8'(tv << 3) & m};
  endfunction
  // Waits for a start after the new temperature is set, then for that conversion
  task automatic conv(input int tv);
    @(posedge clock_in);
    temp <= 14'(tv);
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (start !== 1'b1 && n < 1000);
    if (n >= 1000) cmp("conversion start", 8'h01, 8'h00);
    repeat (CD + 3) @(posedge clock_in);
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_in);
    error_cnt++;
    close_out();
  end
  initial begin
    seed = 79;
    temp = 14'sd0;
    sense = '0;
    sys_rst_in = 1'b1;
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    chk(ADDR_STATUS2, 8'h80, 8'h80);
    foreach (wa[i]) chk(wa[i], rv[i]);
    foreach (wa[i]) begin
      host.wr(wa[i], 8'hff);
      chk(wa[i], we[i]);
    end
    cmp("pin mode", 8'h01, {7'h00, pin});
    cmp("offset low", 8'he0, fcfg.offset_low);
    t = $random(seed);
    host.wr(ADDR_OFF_HI, 8'(t));
    @(posedge clock_in);
    cmp("offset high", 8'(t), fcfg.offset_high);
    chk(8'h77, 8'h00);
    $display("register test done");
    host.wr(ADDR_GEN_CFG, 8'h00);
    host.wr(ADDR_RATE_ALT, 8'h00);
    for (int f = 0; f < 2; f++) begin
      host.wr(ADDR_DIODE_CFG, f ? 8'h0f : 8'h09);
      t = $unsigned($random(seed)) % 8192;
      conv(t);
      e = model(t, f, 0);
      chk(ADDR_S_HI, e.s_hi);
      chk(ADDR_S_LO, e.s_lo);
      chk(ADDR_U_HI, e.u_hi);
      chk(ADDR_U_LO, e.u_lo);
    end
    host.wr(ADDR_U_HI, 8'h5a);
    host.wr(ADDR_STATUS2, 8'h5a);
    chk(ADDR_U_HI, e.u_hi);
    chk(ADDR_STATUS2, 8'h00, 8'h80);
    $display("format test done");
    t = 1000 + ($unsigned($random(seed)) % 3000);
    conv(t);
    e = model(t, 1, 0);
    chk(ADDR_U_HI, e.u_hi);
    conv(t + 1);
    chk(ADDR_U_LO, e.u_lo);
    e = model(t + 1, 1, 0);
    chk(ADDR_U_LO, e.u_lo);
    chk(ADDR_S_HI, e.s_hi);
    conv(t + 2);
    e = model(t + 2, 1, 0);
    chk(ADDR_S_HI, e.s_hi);
    chk(ADDR_S_LO, e.s_lo);
    $display("lock test done");
    sense <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    conv(500);
    e = model(500, 1, 1);
    chk(ADDR_STATUS1, 8'h15, 8'h7f);
    chk(ADDR_U_HI, e.u_hi);
    chk(ADDR_S_HI, e.s_hi);
    chk(ADDR_S_LO, e.s_lo);
    cmp("critical alert", 8'h01, {7'h00, crit});
    host.wr(ADDR_GEN_CFG, 8'h04);
    host.wr(ADDR_DIODE_CFG, 8'h1f);
    repeat (3) @(posedge clock_in);
    cmp("masked critical", 8'h00, {7'h00, crit});
    sense <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    chk(ADDR_STATUS2, 8'h40);
    host.wr(ADDR_DIODE_CFG, 8'h07);
    chk(ADDR_STATUS2, 8'h00);
    $display("status test done");
    host.wr(ADDR_GEN_CFG_ALT, 8'h40);
    repeat (CD + 5) @(posedge clock_in);
    n = starts;
    repeat (400) @(posedge clock_in);
    cmp("standby starts", 8'h00, 8'(starts - n));
    host.wr(ADDR_ONE_SHOT, 8'h00);
    repeat (5) @(posedge clock_in);
    chk(ADDR_STATUS1, 8'h80, 8'h80);
    repeat (100) @(posedge clock_in);
    cmp("one-shot starts", 8'h01, 8'(starts - n));
    chk(ADDR_STATUS1, 8'h00, 8'h80);
    $display("standby test done");
    close_out();
  end
endmodule
`default_nettype wire
